// ### common/acq_pkg.sv
/*
 Constants, register map and types of the acquisition chain register bank.
 Assumes it is compiled before every design file that imports it.
*/
`default_nettype none
package acq_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int RES_W = 16;
   localparam int CNT_W = 3;
   localparam int OSR_W = 11;
   // register offsets
   localparam logic [2:0] OFF_RESULT_LOW = 3'h0;
   localparam logic [2:0] OFF_RESULT_HIGH = 3'h1;
   localparam logic [2:0] OFF_CONV_CTRL = 3'h2;
   localparam logic [2:0] OFF_BIAS_EN = 3'h3;
   localparam logic [2:0] OFF_RATE_STAGE2 = 3'h4;
   localparam logic [2:0] OFF_GAIN = 3'h5;
   localparam logic [2:0] OFF_STAGE3_OFFSET = 3'h6;
   localparam logic [2:0] OFF_CHANNEL = 3'h7;
   localparam int CFG_FIRST = 2;
   localparam int CFG_LAST = 7;
   // field positions
   localparam int CC_TRIGGER_BIT = 7;
   localparam int CC_COUNT_LO = 5;
   localparam int CC_OSR_LO = 2;
   localparam int CC_CONTINUOUS_RUN_BIT = 1;
   localparam int BE_CONV_BIAS_LO = 6;
   localparam int BE_AMP_BIAS_LO = 4;
   localparam int RS_RATE_LO = 6;
   localparam int RS_GAIN_LO = 4;
   localparam int GN_STAGE1_BIT = 7;
   localparam int CH_BUSY_BIT = 7;
   localparam int CH_INPUT_LO = 1;
   localparam int OSR_BASE_EXP = 3;
   // reset values and writable bits, indexed by offset
   localparam logic [7:0] CFG_RESET [CFG_FIRST:CFG_LAST] =
      '{8'h28, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CFG_WMASK [CFG_FIRST:CFG_LAST] =
      '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h3F};
   localparam logic [7:0] READ_IDLE = 8'h00;
   typedef enum {SEQ_IDLE, SEQ_LAUNCH, SEQ_WAIT_LOW, SEQ_WAIT_HIGH} seq_state_t;
endpackage : acq_pkg
`default_nettype wire

// ### design/acq_sync3.sv
/*
 Three-stage synchroniser for one pin-level input with a change filter.
 Assumes the input is asynchronous to sys_clk and idles high.
*/
`default_nettype none
module acq_sync3 (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic pinIn,
   output logic level,
   output logic rise
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic level_reg;
   logic level_next;
   logic rise_reg;
   logic rise_next;

   // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
   always_comb begin
      stage_next = {stage_reg[1:0], pinIn};
      level_next = level_reg;
      if (stage_reg[1] == stage_reg[2]) begin
         level_next = stage_reg[2];
      end
      rise_next = level_next & ~level_reg;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         // done idles high: resetting low would fake a rise
         stage_reg <= 3'h7;
         level_reg <= 1'b1;
         rise_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
         rise_reg <= rise_next;
      end
   end

   assign level = level_reg;
   assign rise = rise_reg;
endmodule : acq_sync3
`default_nettype wire

// ### design/acq_result_hold.sv
/*
 Holding register for the 16-bit conversion result, split into two bytes.
 Assumes the data input is stable whenever load is high.
*/
`default_nettype none
module acq_result_hold
   import acq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [RES_W-1:0] dataIn,
   output logic [DATA_W-1:0] lowByte,
   output logic [DATA_W-1:0] highByte
);
   logic [RES_W-1:0] result_reg;
   logic [RES_W-1:0] result_next;

   always_comb begin
      result_next = load ? dataIn : result_reg;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         result_reg <= 16'h0000;
      end else begin
         result_reg <= result_next;
      end
   end

   assign lowByte = result_reg[7:0];
   assign highByte = result_reg[15:8];
endmodule : acq_result_hold
`default_nettype wire

// ### design/acquisition_chain_config_regs.sv
/*
 Register bank and conversion sequencer of the acquisition chain.
 Field outputs follow their registers at once; the elementary count
 is taken when a sequence begins, so a later write applies next time.
 Assumes a plain register port on sys_clk and a converter that answers
 each start pulse by dropping, then raising, its done level, with its
 result stable while done is high.
*/
// The strobed register port and the placing of the registers were left to the implementer.
//
// Operation
// - eight byte registers: result and configuration
// - low result byte, read-only, resets zero
// - high result byte, writes ignored, resets zero
// - elementary count field bits 6:5, reset 01
// - oversampling field bits 4:2, reset 010
// - converter bias bits 7:6, reset 11
// - amplifier bias bits 5:4, reset 11
// - stage and converter enables bits 3:0
// - first stage gain bit 7, reset 0
// - second stage gain bits 5:4, reset 00
// - second stage offset bits 3:0, reset 0000
// - third stage gain bits 6:0, reset 0
// - third stage offset 6:0, bit 7 zero
// - trigger starts one conversion, reads zero
// - continuous bit keeps restarting conversions
// - two to the n elementary conversions, chopped
// - oversampling ratio two to three plus n
`default_nettype none
module acquisition_chain_config_regs
   import acq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [DATA_W-1:0] regRdData,
   input wire logic convDoneAsync,
   input wire logic [RES_W-1:0] convDataAsync,
   output logic convStart,
   output logic chopPhase,
   output logic busy,
   output logic [1:0] elementaryCountSel,
   output logic [2:0] oversampleSel,
   output logic [OSR_W-1:0] oversampleRatio,
   output logic [1:0] converterBiasSel,
   output logic [1:0] amplifierBiasSel,
   output logic [3:0] stageEnable,
   output logic [1:0] sampleRateSel,
   output logic stage1Gain,
   output logic [1:0] stage2Gain,
   output logic [3:0] stage2Offset,
   output logic [6:0] stage3Gain,
   output logic [6:0] stage3Offset,
   output logic [4:0] inputMuxSel,
   output logic refMuxSel
);

   // ------------------------------------------------------------
   // decoding helpers
   // ------------------------------------------------------------
   function automatic logic isHit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] off
   );
      isHit = (addr == off);
   endfunction : isHit

   function automatic logic [OSR_W-1:0] osrRatio(input logic [2:0] sel);
      logic [3:0] expo;
      expo = 4'(OSR_BASE_EXP) + {1'b0, sel};
      osrRatio = OSR_W'(1) << expo;
   endfunction : osrRatio

   function automatic logic [CNT_W-1:0] elemLastIndex(
      input logic [1:0] sel
   );
      logic [3:0] total;
      total = 4'h1 << sel;
      elemLastIndex = CNT_W'(total - 4'h1);
   endfunction : elemLastIndex

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   logic [DATA_W-1:0] cfgReg [CFG_FIRST:CFG_LAST];
   logic [DATA_W-1:0] cfgNext [CFG_FIRST:CFG_LAST];

   genvar gi;
   generate
      for (gi = CFG_FIRST; gi <= CFG_LAST; gi++) begin : g_cfg
         // unwritable bits are masked at write so they are never stored; channel bit 7 reads busy instead
         always_comb begin
            cfgNext[gi] = cfgReg[gi];
            if (regWrEn && isHit(regAddr, ADDR_W'(gi))) begin
               cfgNext[gi] = regWrData & CFG_WMASK[gi];
            end
         end

         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               cfgReg[gi] <= CFG_RESET[gi];
            end else begin
               cfgReg[gi] <= cfgNext[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // decoded oversampling ratio
   // ------------------------------------------------------------
   logic [OSR_W-1:0] osr_reg;
   logic [OSR_W-1:0] osr_next;

   always_comb begin
      osr_next = osrRatio(cfgNext[OFF_CONV_CTRL][CC_OSR_LO +: 3]);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         osr_reg <= 11'h020;
      end else begin
         osr_reg <= osr_next;
      end
   end

   // ------------------------------------------------------------
   // converter handshake
   // ------------------------------------------------------------
   logic doneLevel;
   logic doneRise;
   logic loadResult;
   logic [DATA_W-1:0] resultLow;
   logic [DATA_W-1:0] resultHigh;

   acq_sync3 u_done_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pinIn(convDoneAsync),
      .level(doneLevel),
      .rise(doneRise)
   );

   // data is bundled with done: only captured after done has settled
   acq_result_hold u_result (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(loadResult),
      .dataIn(convDataAsync),
      .lowByte(resultLow),
      .highByte(resultHigh)
   );

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   seq_state_t state_reg;
   seq_state_t state_next;
   logic pending_reg;
   logic pending_next;
   logic [CNT_W-1:0] elemCnt_reg;
   logic [CNT_W-1:0] elemCnt_next;
   logic [CNT_W-1:0] elemLast_reg;
   logic [CNT_W-1:0] elemLast_next;
   logic chop_reg;
   logic chop_next;
   logic start_reg;
   logic start_next;
   logic busy_reg;
   logic busy_next;
   logic trigWrite;
   logic contMode;
   logic seqBegin;

   always_comb begin
      contMode = cfgReg[OFF_CONV_CTRL][CC_CONTINUOUS_RUN_BIT];
      state_next = state_reg;
      elemCnt_next = elemCnt_reg;
      elemLast_next = elemLast_reg;
      chop_next = chop_reg;
      start_next = 1'b0;
      loadResult = 1'b0;
      seqBegin = 1'b0;
      case (state_reg)
         SEQ_IDLE: begin
            if (pending_reg || contMode) begin
               seqBegin = 1'b1;
               elemCnt_next = '0;
               chop_next = 1'b0;
               // captured here: a write mid-sequence waits for the next
               elemLast_next = elemLastIndex(
                  cfgReg[OFF_CONV_CTRL][CC_COUNT_LO +: 2]);
               state_next = SEQ_LAUNCH;
            end
         end
         SEQ_LAUNCH: begin
            start_next = 1'b1;
            state_next = SEQ_WAIT_LOW;
         end
         SEQ_WAIT_LOW: begin
            // done of the previous conversion must drop first
            if (!doneLevel) begin
               state_next = SEQ_WAIT_HIGH;
            end
         end
         SEQ_WAIT_HIGH: begin
            if (doneRise) begin
               if (elemCnt_reg == elemLast_reg) begin
                  // only the last elementary result is kept
                  loadResult = 1'b1;
                  state_next = SEQ_IDLE;
               end else begin
                  elemCnt_next = elemCnt_reg + CNT_W'(1);
                  chop_next = ~chop_reg;
                  state_next = SEQ_LAUNCH;
               end
            end
         end
         default: begin
            state_next = SEQ_IDLE;
         end
      endcase
      busy_next = (state_next != SEQ_IDLE);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= SEQ_IDLE;
         elemCnt_reg <= 3'h0;
         elemLast_reg <= 3'h0;
         chop_reg <= 1'b0;
         start_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         elemCnt_reg <= elemCnt_next;
         elemLast_reg <= elemLast_next;
         chop_reg <= chop_next;
         start_reg <= start_next;
         busy_reg <= busy_next;
      end
   end

   // ------------------------------------------------------------
   // trigger capture
   // ------------------------------------------------------------
   // a trigger landing in the cycle that begins a sequence stays pending: set wins
   always_comb begin
      trigWrite = regWrEn && isHit(regAddr, OFF_CONV_CTRL)
         && regWrData[CC_TRIGGER_BIT];
      pending_next = pending_reg;
      if (seqBegin) begin
         pending_next = 1'b0;
      end
      if (trigWrite) begin
         pending_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= pending_next;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rdData_reg;
   logic [DATA_W-1:0] rdData_next;

   // data stands only in the cycle after the strobe, zero otherwise
   always_comb begin
      rdData_next = READ_IDLE;
      if (regRdEn) begin
         case (regAddr)
            OFF_RESULT_LOW: begin
               rdData_next = resultLow;
            end
            OFF_RESULT_HIGH: begin
               rdData_next = resultHigh;
            end
            OFF_CONV_CTRL: begin
               // trigger is a strobe only, whatever the store holds
               rdData_next = cfgReg[OFF_CONV_CTRL];
               rdData_next[CC_TRIGGER_BIT] = 1'b0;
            end
            OFF_STAGE3_OFFSET: begin
               rdData_next = cfgReg[OFF_STAGE3_OFFSET];
               rdData_next[DATA_W-1] = 1'b0;
            end
            OFF_CHANNEL: begin
               rdData_next = cfgReg[OFF_CHANNEL];
               rdData_next[CH_BUSY_BIT] = busy_reg;
            end
            default: begin
               // trigger bit and unused bits are never stored
               rdData_next = cfgReg[regAddr];
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_reg <= 8'h00;
      end else begin
         rdData_reg <= rdData_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign regRdData = rdData_reg;
   assign convStart = start_reg;
   assign chopPhase = chop_reg;
   assign busy = busy_reg;
   assign oversampleRatio = osr_reg;
   assign elementaryCountSel =
      cfgReg[OFF_CONV_CTRL][CC_COUNT_LO +: 2];
   assign oversampleSel = cfgReg[OFF_CONV_CTRL][CC_OSR_LO +: 3];
   assign converterBiasSel =
      cfgReg[OFF_BIAS_EN][BE_CONV_BIAS_LO +: 2];
   assign amplifierBiasSel =
      cfgReg[OFF_BIAS_EN][BE_AMP_BIAS_LO +: 2];
   assign stageEnable = cfgReg[OFF_BIAS_EN][3:0];
   assign sampleRateSel =
      cfgReg[OFF_RATE_STAGE2][RS_RATE_LO +: 2];
   assign stage2Gain = cfgReg[OFF_RATE_STAGE2][RS_GAIN_LO +: 2];
   assign stage2Offset = cfgReg[OFF_RATE_STAGE2][3:0];
   assign stage1Gain = cfgReg[OFF_GAIN][GN_STAGE1_BIT];
   assign stage3Gain = cfgReg[OFF_GAIN][6:0];
   assign stage3Offset = cfgReg[OFF_STAGE3_OFFSET][6:0];
   assign inputMuxSel = cfgReg[OFF_CHANNEL][CH_INPUT_LO +: 5];
   assign refMuxSel = cfgReg[OFF_CHANNEL][0];
endmodule : acquisition_chain_config_regs
`default_nettype wire

// ### verification/acquisition_chain_config_regs_monitor.sv
/*
 Port checker of the acquisition chain register bank.
 Assumes it is bound onto the top module: one clock, async reset.
*/
`default_nettype none
module acquisition_chain_config_regs_monitor
   import acq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic convStart,
   input wire logic busy,
   input wire logic [1:0] elementaryCountSel,
   input wire logic [2:0] oversampleSel,
   input wire logic [OSR_W-1:0] oversampleRatio,
   input wire logic [1:0] converterBiasSel,
   input wire logic [1:0] amplifierBiasSel,
   input wire logic [3:0] stageEnable,
   input wire logic [1:0] sampleRateSel,
   input wire logic stage1Gain,
   input wire logic [1:0] stage2Gain,
   input wire logic [3:0] stage2Offset,
   input wire logic [6:0] stage3Gain
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // write data kept one cycle so fields can be compared after the edge
   logic [7:0] wrData_reg;
   logic [7:0] wrData_next;
   always_comb wrData_next = regWrData;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrData_reg <= 8'h00;
      end else begin
         wrData_reg <= wrData_next;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_rd_idle;
      !$past(regRdEn) |-> regRdData == 8'h00;
   endproperty
   property p_rd_trig;
      regRdEn && regAddr == OFF_CONV_CTRL |=> !regRdData[7];
   endproperty
   property p_rd_off;
      regRdEn && regAddr == OFF_STAGE3_OFFSET |=> !regRdData[7];
   endproperty
   property p_wr_ctrl;
      regWrEn && regAddr == OFF_CONV_CTRL
         |=> {elementaryCountSel, oversampleSel} == wrData_reg[6:2];
   endproperty
   property p_wr_bias;
      regWrEn && regAddr == OFF_BIAS_EN |=>
         {converterBiasSel, amplifierBiasSel, stageEnable} == wrData_reg;
   endproperty
   property p_wr_rate;
      regWrEn && regAddr == OFF_RATE_STAGE2 |=>
         {sampleRateSel, stage2Gain, stage2Offset} == wrData_reg;
   endproperty
   property p_wr_gain;
      regWrEn && regAddr == OFF_GAIN
         |=> {stage1Gain, stage3Gain} == wrData_reg;
   endproperty
   property p_launch;
      regWrEn && regAddr == OFF_CONV_CTRL && regWrData[7] && !busy
         |=> ##1 busy ##1 convStart;
   endproperty
   property p_pulse;
      convStart |=> !convStart [*3];
   endproperty
   property p_ratio;
      $stable(oversampleSel) && !busy
         |-> oversampleRatio == (11'h001 << (3 + oversampleSel));
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside read cycle");
   a_rd_trig: assert property (p_rd_trig)
      else $error("trigger bit read back as one");
   a_rd_off: assert property (p_rd_off)
      else $error("unused offset bit read back as one");
   a_wr_ctrl: assert property (p_wr_ctrl)
      else $error("count or oversampling field not written");
   a_wr_bias: assert property (p_wr_bias)
      else $error("bias or enable fields not written");
   a_wr_rate: assert property (p_wr_rate)
      else $error("rate or stage two fields not written");
   a_wr_gain: assert property (p_wr_gain)
      else $error("gain fields not written");
   a_launch: assert property (p_launch)
      else $error("trigger did not launch a conversion");
   a_pulse: assert property (p_pulse)
      else $error("start pulses too close together");
   a_ratio: assert property (p_ratio)
      else $error("oversampling ratio does not match selector");
   c_start: cover property (convStart);
   c_busy_end: cover property ($fell(busy));
   c_rd_ctrl: cover property (regRdEn && regAddr == OFF_CONV_CTRL);
endmodule : acquisition_chain_config_regs_monitor
`default_nettype wire

// ### verification/acquisition_chain_config_regs_bench.sv
/*
 Self-checking bench of the acquisition chain register bank.
 Assumes package and design are compiled first; bench plays converter.
*/
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module acquisition_chain_config_regs_bench
   import acq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00, regRdData, d;
   logic convDoneAsync = 1'b1, convStart, chopPhase, busy, stage1Gain;
   logic [15:0] convDataAsync = 16'h0000;
   logic [1:0] elementaryCountSel, converterBiasSel, amplifierBiasSel;
   logic [1:0] sampleRateSel, stage2Gain;
   logic [2:0] oversampleSel;
   logic [10:0] oversampleRatio;
   logic [3:0] stageEnable, stage2Offset;
   logic [6:0] stage3Gain, stage3Offset;
   logic [4:0] inputMuxSel;
   logic refMuxSel;
   logic [7:0] shadow [8];
   int mismatches = 0, checked = 0;
   always #2.5 sys_clk = ~sys_clk;
   acquisition_chain_config_regs u_dut (.sys_clk, .rst, .regAddr,
      .regWrData, .regWrEn, .regRdEn, .regRdData, .convDoneAsync,
      .convDataAsync, .convStart, .chopPhase, .busy, .elementaryCountSel,
      .oversampleSel, .oversampleRatio, .converterBiasSel,
      .amplifierBiasSel, .stageEnable, .sampleRateSel, .stage1Gain,
      .stage2Gain, .stage2Offset, .stage3Gain, .stage3Offset,
      .inputMuxSel, .refMuxSel);
   function automatic logic [7:0] rst_val(input int a);
      return (a == 2) ? 8'h28 : (a == 3) ? 8'hF0 : 8'h00;
   endfunction : rst_val
   // trigger and unused bits read back as zero, busy bit only while idle
   function automatic logic [7:0] wmask(input int a);
      return (a < 2) ? 8'h00 : (a == 7) ? 8'h3F :
         (a == 2 || a == 6) ? 8'h7F : 8'hFF;
   endfunction : wmask
   task automatic final_report();
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   task automatic wr(input int a, input logic [7:0] v);
      @(posedge sys_clk);
      regAddr <= a[2:0];
      regWrData <= v;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(input int a, output logic [7:0] v);
      @(posedge sys_clk);
      regAddr <= a[2:0];
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1 v = regRdData;
   endtask : rd
   // bounded wait: for a start pulse (0) or for idle (1)
   task automatic wait_sig(input int which);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (n < 300 && !(which == 0 ? convStart === 1'b1 :
         busy === 1'b0));
      if (n >= 300) begin
         mismatches++;
         final_report();
      end
   endtask : wait_sig
   // converter drops done, then raises it with the result settled
   task automatic convert(input logic [15:0] v, input logic chop);
      wait_sig(0);
      `CHK(chopPhase, chop)
      @(posedge sys_clk);
      convDoneAsync <= 1'b0;
      convDataAsync <= ~v;
      repeat (4) @(posedge sys_clk);
      convDataAsync <= v;
      @(posedge sys_clk);
      convDoneAsync <= 1'b1;
   endtask : convert
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int a, n, k;
      logic [15:0] val;
      logic [2:0] osr;
      void'($urandom(32'hB44DDFFB));
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      for (a = 0; a < 8; a++) begin
         rd(a, d);
         `CHK(d, rst_val(a))
         shadow[a] = rst_val(a);
      end
      // all-ones corner first, then random traffic; no trigger here
      for (k = 0; k < 68; k++) begin
         a = (k < 8) ? k : $urandom_range(7);
         d = (k < 8) ? 8'hFF : 8'($urandom);
         if (a == 2) d = d & 8'h7D;
         wr(a, d);
         if (a > 1) shadow[a] = d & wmask(a);
         rd(a, d);
         `CHK(d, shadow[a])
      end
      `CHK(converterBiasSel, shadow[3][7:6])
      `CHK(amplifierBiasSel, shadow[3][5:4])
      `CHK(stageEnable, shadow[3][3:0])
      `CHK(sampleRateSel, shadow[4][7:6])
      `CHK(stage2Gain, shadow[4][5:4])
      `CHK(stage2Offset, shadow[4][3:0])
      `CHK(stage1Gain, shadow[5][7])
      `CHK(stage3Gain, shadow[5][6:0])
      `CHK(elementaryCountSel, shadow[2][6:5])
      `CHK(oversampleSel, shadow[2][4:2])
      `CHK(stage3Offset, shadow[6][6:0])
      `CHK({inputMuxSel, refMuxSel}, shadow[7][5:0])
      for (n = 0; n < 4; n++) begin
         osr = 3'($urandom_range(7));
         val = 16'($urandom);
         wr(2, {1'b1, n[1:0], osr, 2'b00});
         for (k = 0; k < (1 << n); k++)
            convert((k == (1 << n) - 1) ? val : ~val, k[0]);
         wait_sig(1);
         `CHK(oversampleRatio, 11'h001 << (3 + osr))
         rd(0, d);
         `CHK(d, val[7:0])
         rd(1, d);
         `CHK(d, val[15:8])
      end
      // trigger while busy is held and served afterwards
      wr(2, 8'h80);
      convert(16'h0F1E, 1'b0);
      #1 `CHK(busy, 1'b1)
      wr(2, 8'h80);
      convert(16'h5AC3, 1'b0);
      wait_sig(1);
      rd(0, d);
      `CHK(d, 8'hC3)
      wr(2, 8'h02);
      convert(16'h1234, 1'b0);
      convert(16'hA5B6, 1'b0);
      wr(2, 8'h00);
      wait_sig(1);
      rd(1, d);
      `CHK(d, 8'hA5)
      for (k = 0; k < 20; k++) begin
         @(posedge sys_clk);
         #1 `CHK(convStart, 1'b0)
      end
      final_report();
   end
endmodule : acquisition_chain_config_regs_bench
bind acquisition_chain_config_regs acquisition_chain_config_regs_monitor
   u_monitor (.sys_clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
   .regRdData, .convStart, .busy, .elementaryCountSel, .oversampleSel,
   .oversampleRatio, .converterBiasSel, .amplifierBiasSel, .stageEnable,
   .sampleRateSel, .stage1Gain, .stage2Gain, .stage2Offset, .stage3Gain);
`default_nettype wire
